// [hw/mmu_pkg.sv]
`default_nettype none
package mmu_pkg;
  localparam int          ENTRIES    = 64;
  localparam int          IDX_W      = 6;
  localparam int          PAGE_LSB   = 8;
  localparam int          LVL_MSB    = 31;
  localparam int          LVL_LSB    = 29;
  localparam logic [3:0]  FC_CPU     = 4'hF;
  localparam logic [3:0]  BKPT_TYPE  = 4'h0;
  localparam int          TYPE_LSB   = 16;
  localparam int          DESC_VALID = 0;
  localparam int          DESC_WP    = 1;
  localparam logic [7:0]  CNT_RESET  = 8'h00;
  localparam logic [2:0]  STAT_RESET = 3'h0;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  fc;
  } logical_addr_t;

  typedef struct packed {
    logic [31:0] root;
    logic [3:0]  fc;
    logic [23:0] page;
  } cache_key_t;

  typedef struct packed {
    logic [23:0] frame;
    logic        wp;
  } cache_data_t;

  typedef enum logic [1:0] {
    FL_ROOT, FL_ROOT_EA, FL_ROOT_EA_FC
  } flush_mode_t;

  typedef enum logic [2:0] {
    CMD_FLUSH, CMD_PROBE, CMD_VALIDATE, CMD_SAVE, CMD_RESTORE
  } cmd_op_t;

  typedef struct packed {
    cmd_op_t       op;
    flush_mode_t   fl_mode;
    logical_addr_t ea;
  } unit_cmd_t;

  typedef struct packed {
    logic [7:0] bkpt_count;
    logic [2:0] status;
  } iface_state_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WALK_REQ, ST_WALK_WAIT, ST_DONE
  } mmu_state_t;
endpackage : mmu_pkg
`default_nettype wire

// [hw/translation_cache.sv]
`timescale 1ns/1ps
`default_nettype none
module translation_cache (
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  input  wire mmu_pkg::cache_key_t  lk_key,
  output logic                      lk_hit,
  output mmu_pkg::cache_data_t      lk_data,
  input  wire logic                 wr_en,
  input  wire mmu_pkg::cache_key_t  wr_key,
  input  wire mmu_pkg::cache_data_t wr_data,
  input  wire logic                 fl_en,
  input  wire mmu_pkg::flush_mode_t fl_mode,
  input  wire mmu_pkg::cache_key_t  fl_key
);
  mmu_pkg::cache_key_t           tag_r [mmu_pkg::ENTRIES];
  mmu_pkg::cache_data_t          dat_r [mmu_pkg::ENTRIES];
  logic [mmu_pkg::ENTRIES-1:0]   vld_r;
  logic [mmu_pkg::IDX_W-1:0]     rr_r;
  logic [mmu_pkg::IDX_W-1:0]     victim;
  logic                          any_free;

  function automatic logic key_eq(input mmu_pkg::cache_key_t a,
                                  input mmu_pkg::cache_key_t b,
                                  input mmu_pkg::flush_mode_t m);
    key_eq = (a.root == b.root);
    if (m != mmu_pkg::FL_ROOT)
      key_eq = key_eq && (a.page == b.page);
    if (m == mmu_pkg::FL_ROOT_EA_FC)
      key_eq = key_eq && (a.fc == b.fc);
  endfunction : key_eq

  always_comb begin
    lk_hit  = 1'b0;
    lk_data = '0;
    for (int i = 0; i < mmu_pkg::ENTRIES; i++) begin
      if (vld_r[i] && key_eq(tag_r[i], lk_key, mmu_pkg::FL_ROOT_EA_FC)) begin
        lk_hit  = 1'b1;
        lk_data = dat_r[i];
      end
    end
  end

  // free slot first, else round robin victim
  always_comb begin
    any_free = 1'b0;
    victim   = rr_r;
    for (int i = mmu_pkg::ENTRIES - 1; i >= 0; i--) begin
      if (!vld_r[i]) begin
        any_free = 1'b1;
        victim   = i[mmu_pkg::IDX_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rr_r <= '0;
    end else if (wr_en && !any_free) begin
      rr_r <= rr_r + 1'b1;
    end
  end

  // flush before fill so a same-cycle fill survives
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      vld_r <= '0;
    end else begin
      for (int i = 0; i < mmu_pkg::ENTRIES; i++) begin
        if (fl_en && key_eq(tag_r[i], fl_key, fl_mode))
          vld_r[i] <= 1'b0;
      end
      if (wr_en)
        vld_r[victim] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      tag_r[victim] <= wr_key;
      dat_r[victim] <= wr_data;
    end
  end

  chk_fill_hits: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_en && !fl_en ##1 (lk_key == $past(wr_key)) |-> lk_hit)
    else $error("filled entry not found on next lookup");
  chk_flush_miss: assert property (@(posedge ref_clk) disable iff (!nrst)
    fl_en && fl_mode == mmu_pkg::FL_ROOT_EA_FC && !wr_en
    ##1 (lk_key == $past(fl_key)) |-> !lk_hit)
    else $error("flushed entry still hits");
endmodule : translation_cache
`default_nettype wire

// [hw/paged_translation_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module paged_translation_unit (
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  // logical master side; strobe held until an answer, then dropped
  input  wire logic                   cyc_req,
  input  wire mmu_pkg::logical_addr_t logical_address_bus,
  output logic [31:0]                 phys_addr_r,
  output logic                        phys_strobe_r,
  output logic                        abort_retry_r,
  output logic                        fault_r,
  output logic [31:0]                 bkpt_data_r,
  output logic                        bkpt_ack_r,
  // configuration
  input  wire logic [63:0]            root_ptr,
  input  wire logic [2:0]             cur_access_level,
  input  wire logic [31:0]            bkpt_opcode,
  input  wire logic [7:0]             bkpt_limit,
  input  wire logic                   bkpt_immediate,
  // table memory
  output logic                        mem_rd_r,
  output logic [31:0]                 mem_addr_r,
  input  wire logic                   mem_ack,
  input  wire logic [31:0]            mem_rdata,
  // command port
  input  wire logic                   cmd_valid,
  input  wire mmu_pkg::unit_cmd_t     cmd,
  input  wire mmu_pkg::iface_state_t  restore_state,
  output logic                        cmd_done_r,
  output logic                        validate_trap_r,
  output logic [2:0]                  status_r,
  output mmu_pkg::iface_state_t       saved_state_r
);
  mmu_pkg::mmu_state_t   state_r;
  mmu_pkg::cache_key_t   lk_key;
  mmu_pkg::cache_key_t   walk_key_r;
  mmu_pkg::cache_data_t  lk_data;
  logic                  lk_hit;
  logic                  walk_probe_r;
  logic [7:0]            bkpt_count_r;
  logic                  take_bus;
  logic                  take_cmd;
  logic                  priv_bad;
  logic                  is_bkpt;
  logic                  desc_ok;
  logic                  fill;

  function automatic mmu_pkg::cache_key_t make_key(
      input logic [31:0] root, input mmu_pkg::logical_addr_t key_src);
    make_key.root = root;
    make_key.fc   = key_src.fc;
    make_key.page = key_src.addr[31:mmu_pkg::PAGE_LSB];
  endfunction : make_key

  function automatic logic below_level(input logic [31:0] a,
                                       input logic [2:0]  cur_lvl);
    below_level = a[mmu_pkg::LVL_MSB:mmu_pkg::LVL_LSB] < cur_lvl;
  endfunction : below_level

  // one-level table: word index is fc and address bits 17..8
  function automatic logic [31:0] walk_addr(input logic [31:0] root,
                                            input mmu_pkg::cache_key_t k);
    walk_addr = root + {16'h0000, k.fc, k.page[9:0], 2'b00};
  endfunction : walk_addr

  assign take_bus = (state_r == mmu_pkg::ST_IDLE) && cyc_req;
  assign take_cmd = (state_r == mmu_pkg::ST_IDLE) && !cyc_req && cmd_valid;
  // a probe must report the hit of its own address, not the bus's
  assign lk_key   = make_key(root_ptr[31:0],
                             take_cmd ? cmd.ea : logical_address_bus);
  assign priv_bad = below_level(logical_address_bus.addr,
                                cur_access_level);
  assign is_bkpt  = (logical_address_bus.fc == mmu_pkg::FC_CPU) &&
                    (logical_address_bus.addr[mmu_pkg::TYPE_LSB+3:
                     mmu_pkg::TYPE_LSB] == mmu_pkg::BKPT_TYPE);
  assign desc_ok  = mem_rdata[mmu_pkg::DESC_VALID];
  assign fill     = (state_r == mmu_pkg::ST_WALK_WAIT) && mem_ack &&
                    desc_ok && !walk_probe_r;

  translation_cache i_translation_cache (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .lk_key  (lk_key),
    .lk_hit  (lk_hit),
    .lk_data (lk_data),
    .wr_en   (fill),
    .wr_key  (walk_key_r),
    .wr_data ({mem_rdata[31:8], mem_rdata[mmu_pkg::DESC_WP]}),
    .fl_en   (take_cmd && cmd.op == mmu_pkg::CMD_FLUSH),
    .fl_mode (cmd.fl_mode),
    .fl_key  (make_key(root_ptr[31:0], cmd.ea))
  );

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r      <= mmu_pkg::ST_IDLE;
      walk_probe_r <= 1'b0;
      walk_key_r   <= '0;
    end else begin
      case (state_r)
        mmu_pkg::ST_IDLE: begin
          if (take_bus) begin
            if (!priv_bad && !is_bkpt && !lk_hit) begin
              walk_key_r   <= lk_key;
              walk_probe_r <= 1'b0;
              state_r      <= mmu_pkg::ST_WALK_REQ;
            end else begin
              state_r <= mmu_pkg::ST_DONE;
            end
          end else if (take_cmd && cmd.op == mmu_pkg::CMD_PROBE) begin
            walk_key_r   <= make_key(root_ptr[31:0], cmd.ea);
            walk_probe_r <= 1'b1;
            state_r      <= mmu_pkg::ST_WALK_REQ;
          end
        end
        mmu_pkg::ST_WALK_REQ:  state_r <= mmu_pkg::ST_WALK_WAIT;
        mmu_pkg::ST_WALK_WAIT: begin
          if (mem_ack)
            state_r <= walk_probe_r ? mmu_pkg::ST_IDLE : mmu_pkg::ST_DONE;
        end
        mmu_pkg::ST_DONE: begin
          // master must drop its strobe before the retry
          if (!cyc_req)
            state_r <= mmu_pkg::ST_IDLE;
        end
        default: state_r <= mmu_pkg::ST_IDLE;
      endcase
    end
  end

  // table memory read; held until acknowledged
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mem_rd_r   <= 1'b0;
      mem_addr_r <= '0;
    end else if (state_r == mmu_pkg::ST_WALK_REQ) begin
      mem_rd_r   <= 1'b1;
      mem_addr_r <= walk_addr(root_ptr[31:0], walk_key_r);
    end else if (mem_ack) begin
      mem_rd_r   <= 1'b0;
    end
  end

  // one-cycle answers to the logical master
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phys_addr_r   <= '0;
      phys_strobe_r <= 1'b0;
      abort_retry_r <= 1'b0;
      fault_r       <= 1'b0;
      bkpt_ack_r    <= 1'b0;
      bkpt_data_r   <= '0;
    end else begin
      phys_strobe_r <= 1'b0;
      abort_retry_r <= 1'b0;
      fault_r       <= 1'b0;
      bkpt_ack_r    <= 1'b0;
      if (take_bus) begin
        if (priv_bad) begin
          fault_r <= 1'b1;
        end else if (is_bkpt) begin
          if (!bkpt_immediate && bkpt_count_r < bkpt_limit) begin
            bkpt_ack_r  <= 1'b1;
            bkpt_data_r <= bkpt_opcode;
          end else begin
            fault_r <= 1'b1;
          end
        end else if (lk_hit) begin
          phys_strobe_r <= 1'b1;
          phys_addr_r   <= {lk_data.frame,
                            logical_address_bus.addr[mmu_pkg::PAGE_LSB-1:0]};
        end else begin
          abort_retry_r <= 1'b1;
        end
      end else if (state_r == mmu_pkg::ST_WALK_WAIT && mem_ack &&
                   !walk_probe_r && !desc_ok) begin
        fault_r <= 1'b1;
      end
    end
  end

  // breakpoint replacement count; restarts when the error is signalled
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bkpt_count_r <= mmu_pkg::CNT_RESET;
    end else if (take_cmd && cmd.op == mmu_pkg::CMD_RESTORE) begin
      bkpt_count_r <= restore_state.bkpt_count;
    end else if (take_bus && !priv_bad && is_bkpt) begin
      if (!bkpt_immediate && bkpt_count_r < bkpt_limit)
        bkpt_count_r <= bkpt_count_r + 8'h01;
      else
        bkpt_count_r <= mmu_pkg::CNT_RESET;
    end
  end

  // status: {walk found valid, write protected, was cached}
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      status_r <= mmu_pkg::STAT_RESET;
    end else if (take_cmd && cmd.op == mmu_pkg::CMD_RESTORE) begin
      status_r <= restore_state.status;
    end else if (take_cmd && cmd.op == mmu_pkg::CMD_PROBE) begin
      status_r <= {2'b00, lk_hit};
    end else if (state_r == mmu_pkg::ST_WALK_WAIT && mem_ack &&
                 walk_probe_r) begin
      status_r <= {desc_ok, mem_rdata[mmu_pkg::DESC_WP],
                   status_r[0]};
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_done_r      <= 1'b0;
      validate_trap_r <= 1'b0;
      saved_state_r   <= '0;
    end else begin
      cmd_done_r      <= (take_cmd && cmd.op != mmu_pkg::CMD_PROBE) ||
                         (state_r == mmu_pkg::ST_WALK_WAIT && mem_ack &&
                          walk_probe_r);
      validate_trap_r <= take_cmd && cmd.op == mmu_pkg::CMD_VALIDATE &&
        below_level(cmd.ea.addr, cur_access_level);
      if (take_cmd && cmd.op == mmu_pkg::CMD_SAVE)
        saved_state_r <= '{bkpt_count: bkpt_count_r,
                           status: status_r};
    end
  end

  chk_priv_nostrobe: assert property (@(posedge ref_clk) disable iff (!nrst)
    take_bus && priv_bad |=> fault_r && !phys_strobe_r ##1
    !phys_strobe_r[*2])
    else $error("strobe during privilege violation");
  chk_priv_fault: assert property (@(posedge ref_clk) disable iff (!nrst)
    take_bus && logical_address_bus.addr[31:29] < cur_access_level
    |=> fault_r)
    else $error("privilege violation not faulted");
  chk_miss_abort: assert property (@(posedge ref_clk) disable iff (!nrst)
    take_bus && !priv_bad && !is_bkpt && !lk_hit
    |=> abort_retry_r ##1 mem_rd_r)
    else $error("miss did not abort and walk");
  chk_hit_strobe: assert property (@(posedge ref_clk) disable iff (!nrst)
    take_bus && !priv_bad && !is_bkpt && lk_hit
    |=> phys_strobe_r && !abort_retry_r)
    else $error("hit not translated");
  chk_walk_addr: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(mem_rd_r) |-> mem_addr_r[1:0] == 2'b00 &&
    mem_addr_r >= $past(root_ptr[31:0]))
    else $error("walk address not rooted");
  chk_bad_desc: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_r == mmu_pkg::ST_WALK_WAIT && mem_ack && !walk_probe_r &&
    !mem_rdata[0] |-> !fill ##1 fault_r)
    else $error("invalid descriptor not faulted");
  chk_bkpt_count: assert property (@(posedge ref_clk) disable iff (!nrst)
    take_bus && !priv_bad && is_bkpt && bkpt_immediate
    |=> fault_r && !bkpt_ack_r && bkpt_count_r == 8'h00)
    else $error("immediate breakpoint error missing");
  chk_bkpt_ack: assert property (@(posedge ref_clk) disable iff (!nrst)
    bkpt_ack_r |-> bkpt_data_r == $past(bkpt_opcode) &&
    $past(bkpt_count_r) < $past(bkpt_limit))
    else $error("breakpoint ack without opcode");
  chk_validate: assert property (@(posedge ref_clk) disable iff (!nrst)
    take_cmd && cmd.op == mmu_pkg::CMD_VALIDATE &&
    cmd.ea.addr[31:29] >= cur_access_level |=> !validate_trap_r)
    else $error("spurious validate trap");
  chk_save_restore: assert property (@(posedge ref_clk) disable iff (!nrst)
    take_cmd && cmd.op == mmu_pkg::CMD_RESTORE
    |=> bkpt_count_r == $past(restore_state.bkpt_count) &&
    status_r == $past(restore_state.status))
    else $error("restore did not reload state");
endmodule : paged_translation_unit
`default_nettype wire

// [tb/table_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module table_mem_model #(
  parameter logic [23:0] FRAME_XOR = 24'h5A5A5A
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        mem_rd_r,
  input  wire logic [31:0] mem_addr_r,
  input  wire logic [3:0]  lat,
  input  wire logic [31:0] bad_addr,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [3:0] cnt_r;

  // descriptor: frame from address, wp from bit 2, valid unless bad_addr
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r     <= 4'h0;
      mem_ack   <= 1'b0;
      mem_rdata <= 32'hA5A55A5A;
    end else begin
      mem_ack   <= 1'b0;
      // data outside the ack cycle keeps toggling so nothing stale passes
      mem_rdata <= ~mem_rdata;
      if (mem_rd_r && !mem_ack) begin
        if (cnt_r >= lat) begin
          cnt_r     <= 4'h0;
          mem_ack   <= 1'b1;
          mem_rdata <= {mem_addr_r[31:8] ^ FRAME_XOR, 6'h00, mem_addr_r[2],
                        mem_addr_r != bad_addr};
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end
endmodule : table_mem_model
`default_nettype wire

// [tb/test_paged_translation_unit.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_paged_translation_unit;
  logic                   ref_clk, nrst, cyc_req, cmd_valid;
  logic                   bkpt_immediate, phys_strobe_r, abort_retry_r;
  logic                   fault_r, bkpt_ack_r, mem_rd_r, mem_ack;
  logic                   cmd_done_r, validate_trap_r, trap_seen;
  mmu_pkg::logical_addr_t logical_address_bus;
  mmu_pkg::unit_cmd_t     cmd;
  mmu_pkg::iface_state_t  restore_state, saved_state_r;
  logic [63:0]            root_ptr;
  logic [31:0]            phys_addr_r, bkpt_data_r, bkpt_opcode, mem_addr_r;
  logic [31:0]            mem_rdata, bad_addr, rnd, maddr_seen;
  logic [31:0]            pa [6];
  logic [3:0]             pf [6];
  logic [3:0]             lat;
  logic [2:0]             cur_access_level, status_r;
  logic [7:0]             bkpt_limit;
  logic [31:0]            ref_map [logic [27:0]];
  logic [27:0]            dq [$];
  int                     fail_count, n_tests, r;

  paged_translation_unit i_paged_translation_unit (
    .ref_clk(ref_clk), .nrst(nrst), .cyc_req(cyc_req),
    .logical_address_bus(logical_address_bus), .phys_addr_r(phys_addr_r),
    .phys_strobe_r(phys_strobe_r), .abort_retry_r(abort_retry_r),
    .fault_r(fault_r), .bkpt_data_r(bkpt_data_r), .bkpt_ack_r(bkpt_ack_r),
    .root_ptr(root_ptr), .cur_access_level(cur_access_level),
    .bkpt_opcode(bkpt_opcode), .bkpt_limit(bkpt_limit),
    .bkpt_immediate(bkpt_immediate), .mem_rd_r(mem_rd_r),
    .mem_addr_r(mem_addr_r), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .cmd_valid(cmd_valid), .cmd(cmd), .restore_state(restore_state),
    .cmd_done_r(cmd_done_r), .validate_trap_r(validate_trap_r),
    .status_r(status_r), .saved_state_r(saved_state_r));

  table_mem_model i_table_mem_model (
    .ref_clk(ref_clk), .nrst(nrst), .mem_rd_r(mem_rd_r),
    .mem_addr_r(mem_addr_r), .lat(lat), .bad_addr(bad_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 32; i++) begin
      s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    end
    return s;
  endfunction : lfsr

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // code: 0 phys, 1 abort, 2 fault, 3 bkpt ack, 4 abort then fault
  task automatic bus(input logic [31:0] a, input logic [3:0] f,
                     output int c);
    logic seen;
    c = -1;
    seen = 1'b0;
    @(negedge ref_clk);
    cyc_req = 1'b1;
    logical_address_bus = '{addr: a, fc: f};
    for (int i = 0; i < 8 && c < 0; i++) begin
      @(posedge ref_clk);
      #1;
      if (phys_strobe_r) c = 0;
      else if (abort_retry_r) c = 1;
      else if (fault_r) c = 2;
      else if (bkpt_ack_r) c = 3;
    end
    @(negedge ref_clk);
    cyc_req = 1'b0;
    for (int i = 0; i < 40 && c == 1; i++) begin
      @(posedge ref_clk);
      #1;
      if (mem_rd_r) begin
        seen = 1'b1;
        maddr_seen = mem_addr_r;
      end
      if (fault_r) c = 4;
      else if (seen && !mem_rd_r) break;
    end
    @(negedge ref_clk);
  endtask : bus

  task automatic access(input logic [31:0] a, input logic [3:0] f);
    logic [31:0] m;
    logic [27:0] k;
    int          c;
    k = {f, a[31:8]};
    m = root_ptr[31:0] + {16'h0000, f, a[17:8], 2'b00};
    bus(a, f, c);
    if (!ref_map.exists(k)) begin
      `CHK(c, 1)
      `CHK(maddr_seen, m)
      ref_map[k] = m;
      bus(a, f, c); // retry of the aborted cycle
    end
    `CHK(c, 0)
    `CHK(phys_addr_r, {m[31:8] ^ 24'h5A5A5A, a[7:0]})
  endtask : access

  task automatic command(input mmu_pkg::cmd_op_t o, input logic [1:0] m,
                         input logic [31:0] a, input logic [3:0] f);
    trap_seen = 1'b0;
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd.op = o;
    cmd.fl_mode = mmu_pkg::flush_mode_t'(m);
    cmd.ea = '{addr: a, fc: f};
    for (int i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      #1;
      if (validate_trap_r) trap_seen = 1'b1;
      if (cmd_done_r) break;
    end
    `CHK(cmd_done_r, 1'b1)
    @(negedge ref_clk);
    cmd_valid = 1'b0;
  endtask : command

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    #300000;
    fail_count++;
    conclude();
  end

  initial begin
    {nrst, cyc_req, cmd_valid, bkpt_immediate} = 4'h0;
    logical_address_bus = '0;
    cmd = '0;
    restore_state = '0;
    root_ptr = 64'h0000_0000_0001_0000;
    cur_access_level = 3'h2;
    bkpt_opcode = 32'h1234_ABCD;
    bkpt_limit = 8'h03;
    lat = 4'h0;
    bad_addr = 32'hFFFF_FFFC;
    rnd = 32'h0000_0057;
    fail_count = 0;
    n_tests = 0;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      lat = rnd[7:4];
      pa[i] = rnd | 32'h8000_0000;
      pf[i] = {1'b0, rnd[10:8]};
      access(pa[i], pf[i]);
      access(pa[i], pf[i]);
    end
    cur_access_level = 3'h5;
    bus({3'h4, pa[0][28:0]}, pf[0], r);
    `CHK(r, 2)
    access({3'h5, pa[0][28:0]}, pf[0]);
    cur_access_level = 3'h2;
    bad_addr = root_ptr[31:0] + {16'h0000, pf[1], ~pa[1][17:8], 2'b00};
    repeat (2) begin
      bus({pa[1][31:18], ~pa[1][17:8], pa[1][7:0]}, pf[1], r);
      `CHK(r, 4)
    end
    bad_addr = 32'hFFFF_FFFC;
    // breakpoint acknowledge is a read in CPU space
    for (int j = 0; j < 4; j++) begin
      bus(32'hE000_0000, 4'hF, r);
      `CHK(r, (j < 3) ? 3 : 2)
      if (j == 0) `CHK(bkpt_data_r, bkpt_opcode)
    end
    bkpt_immediate = 1'b1;
    bus(32'hE000_0000, 4'hF, r);
    `CHK(r, 2)
    bkpt_immediate = 1'b0;
    command(mmu_pkg::CMD_VALIDATE, 2'h0, 32'h2000_0000, 4'h1);
    `CHK(trap_seen, 1'b1)
    command(mmu_pkg::CMD_VALIDATE, 2'h0, 32'h6000_0000, 4'h1);
    `CHK(trap_seen, 1'b0)
    command(mmu_pkg::CMD_PROBE, 2'h0, pa[2], pf[2]);
    `CHK(status_r, {1'b1, pa[2][8], 1'b1})
    for (int m = 0; m < 3; m++) begin
      // flushed key left on the bus so the flush-miss check is exercised
      access(pa[4], pf[4]);
      access(pa[3], pf[3]);
      command(mmu_pkg::CMD_FLUSH, m[1:0], pa[3], pf[3]);
      dq.delete();
      foreach (ref_map[kk]) begin
        if (m == 0 || (kk[23:0] == pa[3][31:8] &&
            (m == 1 || kk[27:24] == pf[3]))) dq.push_back(kk);
      end
      foreach (dq[n]) ref_map.delete(dq[n]);
      access(pa[3], pf[3]);
      access(pa[4], pf[4]);
    end
    command(mmu_pkg::CMD_PROBE, 2'h0, {3'h7, pa[5][28:0]}, pf[5]);
    `CHK(status_r[0], 1'b0)
    restore_state = '{bkpt_count: 8'h02, status: 3'h5};
    command(mmu_pkg::CMD_RESTORE, 2'h0, 32'h0000_0000, 4'h0);
    command(mmu_pkg::CMD_SAVE, 2'h0, 32'h0000_0000, 4'h0);
    `CHK(saved_state_r, restore_state)
    bus(32'hE000_0000, 4'hF, r);
    `CHK(r, 3)
    bus(32'hE000_0000, 4'hF, r);
    `CHK(r, 2)
    conclude();
  end
endmodule : test_paged_translation_unit
`default_nettype wire
